// ---- common/sdtsc_consts.svh ----
// constants for the serdes test and status control block
`ifndef SDTSC_CONSTS_SVH
`define SDTSC_CONSTS_SVH

// timing
`define SDTSC_CLK_PERIOD_NS   100
`define SDTSC_POR_MAX_NS      1000000
`define SDTSC_BIT_CLK_MULT    10
`define SDTSC_WORD_BITS       (2 * `SDTSC_BIT_CLK_MULT)
`define SDTSC_PASS_GOOD_BITS  8'h7F

// pattern sequence
`define SDTSC_PRBS_SEED       7'h7F

// register byte addresses
`define SDTSC_ADR_CTRL        8'h00
`define SDTSC_ADR_STATUS      8'h04
`define SDTSC_ADR_IRQ_STAT    8'h08
`define SDTSC_ADR_IRQ_MASK    8'h0C
`define SDTSC_ADR_TX_WORD     8'h10
`define SDTSC_ADR_RX_WORD     8'h14

// control fields and reset values
`define SDTSC_CTRL_ENABLE     0
`define SDTSC_CTRL_LOOPBACK   1
`define SDTSC_CTRL_PATTERN    2
`define SDTSC_ENABLE_RST      1'h1
`define SDTSC_IRQ_MASK_RST    3'h0

// status fields
`define SDTSC_ST_LOSS         0
`define SDTSC_ST_PASS         1
`define SDTSC_ST_POR          2
`define SDTSC_ST_DOWN         3

// interrupt event fields
`define SDTSC_EV_LOSS         0
`define SDTSC_EV_PERR         1
`define SDTSC_EV_PASS         2

// frame field positions
`define SDTSC_FR_LOWER_K      16
`define SDTSC_FR_UPPER_K      17

`endif

// ---- common/sdtsc_pkg.sv ----
// types shared by the serdes test and status control block
package sdtsc_pkg;

  typedef enum logic [1:0] {PWR_POR, PWR_DOWN, PWR_RUN} sdtsc_pwr_e;

  typedef logic [15:0] sdtsc_word_t;
  typedef logic [19:0] sdtsc_frame_t;
  typedef logic [4:0]  sdtsc_idx_t;
  typedef logic [2:0]  sdtsc_irq_t;

endpackage : sdtsc_pkg

// ---- logic/sdtsc_prbs_chk.sv ----
// self-synchronising checker for the seven-stage pseudorandom stream
`timescale 1ns/10ps
`include "sdtsc_consts.svh"
module sdtsc_prbs_chk (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control and stream
  input  wire logic run,
  input  wire logic bit_in,
  // results
  output logic      pass,
  output logic      err
);
  import sdtsc_pkg::*;

  logic [6:0] hist;
  logic [2:0] fill;
  logic [7:0] good;
  logic       locked;
  logic       expect_bit;

  assign locked     = (fill == 3'h7);
  assign expect_bit = hist[6] ^ hist[5];

  // history fills from the stream itself, so no seed agreement is needed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist <= 7'h00;
      fill <= 3'h0;
    end else if (!run) begin
      hist <= 7'h00;
      fill <= 3'h0;
    end else begin
      hist <= {hist[5:0], bit_in};
      if (!locked) begin
        fill <= fill + 3'h1;
      end
    end
  end

  // pass only after a full sequence of matching bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good <= 8'h00;
      pass <= 1'b0;
      err  <= 1'b0;
    end else if (!run || !locked) begin
      good <= 8'h00;
      pass <= 1'b0;
      err  <= 1'b0;
    end else if (bit_in != expect_bit) begin
      good <= 8'h00;
      pass <= 1'b0;
      err  <= 1'b1;
    end else begin
      err <= 1'b0;
      if (good == `SDTSC_PASS_GOOD_BITS) begin
        pass <= 1'b1;
      end else begin
        good <= good + 8'h01;
      end
    end
  end

endmodule : sdtsc_prbs_chk

// ---- logic/sdtsc_prbs_gen.sv ----
// seven-stage pseudorandom bit generator for the transmit path
`timescale 1ns/10ps
`include "sdtsc_consts.svh"
module sdtsc_prbs_gen (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  // stream
  output logic      bit_out
);
  import sdtsc_pkg::*;

  logic [6:0] lfsr;

  // x^7 + x^6 + 1, one bit per cycle; reseed when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr    <= `SDTSC_PRBS_SEED;
      bit_out <= 1'b0;
    end else if (!run) begin
      lfsr    <= `SDTSC_PRBS_SEED;
      bit_out <= 1'b0;
    end else begin
      lfsr    <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      bit_out <= lfsr[6] ^ lfsr[5];
    end
  end

endmodule : sdtsc_prbs_gen

// ---- logic/sdtsc_top.sv ----
// test, status and clocking control of the serdes transceiver
`timescale 1ns/10ps
`include "sdtsc_consts.svh"
module sdtsc_top #(
  parameter int POR_TIME_NS = `SDTSC_POR_MAX_NS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // wishbone slave
  input  wire logic                 wb_cyc,
  input  wire logic                 wb_stb,
  input  wire logic                 wb_we,
  input  wire logic [7:0]           wb_adr,
  input  wire logic [3:0]           wb_sel,
  input  wire logic [31:0]          wb_wdata,
  output logic      [31:0]          wb_rdata,
  output logic                      wb_ack,
  // serial line and loss detector
  input  wire logic                 serial_in,
  input  wire logic                 signal_loss,
  output logic                      serial_out,
  output logic                      serial_oe,
  // receive pins
  output sdtsc_pkg::sdtsc_word_t    rx_data,
  output logic                      rx_data_oe,
  output logic                      rx_upper_kflag_or_sigloss,
  output logic                      rx_upper_oe,
  output logic                      rx_lower_kflag_or_pattern_pass,
  output logic                      rx_lower_oe,
  output logic                      rx_word_clock,
  // interrupt
  output logic                      irq
);
  import sdtsc_pkg::*;

  // reset length in whole words, rounded down so it ends inside the limit
  localparam int POR_CYC_RAW   = POR_TIME_NS / `SDTSC_CLK_PERIOD_NS;
  localparam int POR_WORDS_RAW = POR_CYC_RAW / `SDTSC_WORD_BITS;
  localparam int POR_WORDS     = (POR_WORDS_RAW < 1) ? 1 : POR_WORDS_RAW;
  localparam logic [15:0] POR_LAST = 16'(POR_WORDS - 1);
  localparam sdtsc_idx_t  LAST_IDX = 5'(`SDTSC_WORD_BITS - 1);
  localparam sdtsc_idx_t  HALF_IDX = 5'(`SDTSC_BIT_CLK_MULT);

  // input synchronisers
  logic [1:0]   sync_a;
  logic [1:0]   sync_b;
  logic         serial_sync;
  logic         loss_sync;

  // software controls
  logic         enable;
  logic         loopback_select;
  logic         pattern_test_select;
  sdtsc_word_t  tx_word;
  logic         tx_lower_kflag;
  logic         tx_upper_kflag;
  sdtsc_irq_t   irq_stat;
  sdtsc_irq_t   irq_mask;

  // power and timing
  sdtsc_pwr_e   pwr_state;
  logic [15:0]  por_cnt;
  sdtsc_idx_t   bit_idx;
  logic         word_tick;
  logic         run;

  // datapath
  sdtsc_frame_t tx_shift;
  sdtsc_frame_t tx_frame;
  sdtsc_frame_t rx_shift;
  sdtsc_frame_t rx_frame;
  logic         rx_bit;
  logic         prbs_bit;
  logic         pattern_run;
  logic         pattern_pass;
  logic         pattern_err;
  logic         loss_eff;
  logic         loss_q;
  logic         pass_q;
  sdtsc_irq_t   irq_event;

  // bus
  logic         bus_req;
  logic         bus_wr;
  sdtsc_irq_t   irq_clear;
  logic [31:0]  next_rdata;

  // two flops on the serial_in and signal_loss inputs before any logic looks at them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else begin
      sync_a <= {signal_loss, serial_in};
      sync_b <= sync_a;
    end
  end

  assign serial_sync = sync_b[0];
  assign loss_sync   = sync_b[1];

  // word divider: one reference period is twenty serial bit slots,
  // i.e. ten bit clock periods with a bit on each edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx <= 5'h00;
    end else if (bit_idx == LAST_IDX) begin
      bit_idx <= 5'h00;
    end else begin
      bit_idx <= bit_idx + 5'h01;
    end
  end

  assign word_tick = (bit_idx == LAST_IDX);

  // power sequencing: reset interval counts reference periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= PWR_POR;
      por_cnt   <= 16'h0000;
    end else begin
      unique case (pwr_state)
        PWR_POR: begin
          if (word_tick) begin
            if (por_cnt == POR_LAST) begin
              pwr_state <= enable ? PWR_RUN : PWR_DOWN;
            end else begin
              por_cnt <= por_cnt + 16'h0001;
            end
          end
        end
        PWR_DOWN: begin
          if (enable && word_tick) begin // restart on a word edge
            pwr_state <= PWR_RUN;
          end
        end
        PWR_RUN: begin
          if (!enable) begin
            pwr_state <= PWR_DOWN;
          end
        end
      endcase
    end
  end

  assign run         = (pwr_state == PWR_RUN);
  assign pattern_run = run & pattern_test_select;

  // transmit frame, low bit first
  assign tx_frame = {2'b00, tx_upper_kflag, tx_lower_kflag, tx_word};

  // serializer: reload once per reference period, shift every slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 20'h00000;
    end else if (!run) begin
      tx_shift <= 20'h00000;
    end else if (word_tick) begin
      tx_shift <= tx_frame;
    end else begin
      tx_shift <= {1'b0, tx_shift[19:1]};
    end
  end

  // line bit: pattern replaces the parallel word entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
      serial_oe  <= 1'b0;
    end else begin
      serial_out <= run & (pattern_test_select ? prbs_bit
                                               : tx_shift[0]);
      serial_oe  <= run & ~loopback_select;
    end
  end

  sdtsc_prbs_gen u_gen (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (pattern_run),
    .bit_out (prbs_bit)
  );

  // loopback takes the bit we are driving, even while the driver floats
  assign rx_bit = loopback_select ? serial_out : serial_sync;

  // deserializer: the frame completes one slot after the reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 20'h00000;
      rx_frame <= 20'h00000;
    end else if (!run) begin
      rx_shift <= 20'h00000;
      rx_frame <= 20'h00000;
    end else begin
      rx_shift <= {rx_bit, rx_shift[19:1]};
      if (bit_idx == 5'h00) begin
        rx_frame <= {rx_bit, rx_shift[19:1]};
      end
    end
  end

  // checker sees whatever the receiver sees, so loopback gives self-test
  sdtsc_prbs_chk u_chk (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (pattern_run),
    .bit_in (rx_bit),
    .pass   (pattern_pass),
    .err    (pattern_err)
  );

  // the loss detector watches the external line only
  assign loss_eff = loss_sync & ~loopback_select;

  // receive pins; loss forces the invalid all-ones code on both bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data                        <= 16'h0000;
      rx_upper_kflag_or_sigloss      <= 1'b0;
      rx_lower_kflag_or_pattern_pass <= 1'b0;
    end else if (loss_eff) begin
      rx_data                        <= 16'hFFFF;
      rx_upper_kflag_or_sigloss      <= 1'b1;
      rx_lower_kflag_or_pattern_pass <= 1'b1;
    end else begin
      rx_data                   <= rx_frame[15:0];
      rx_upper_kflag_or_sigloss <= rx_frame[`SDTSC_FR_UPPER_K];
      rx_lower_kflag_or_pattern_pass <= pattern_test_select
          ? pattern_pass
          : rx_frame[`SDTSC_FR_LOWER_K];
    end
  end

  // pin drivers float during reset; power-down keeps the upper flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_oe    <= 1'b0;
      rx_upper_oe   <= 1'b0;
      rx_lower_oe   <= 1'b0;
      rx_word_clock <= 1'b0;
    end else begin
      rx_data_oe    <= run;
      rx_upper_oe   <= (pwr_state != PWR_POR);
      rx_lower_oe   <= run;
      rx_word_clock <= run & (bit_idx < HALF_IDX);
    end
  end

  // interrupt sources: loss onset, checker mismatch, pass onset
  assign irq_event = {pattern_pass & ~pass_q,
                      pattern_err,
                      loss_eff & ~loss_q};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_q <= 1'b0;
      pass_q <= 1'b0;
    end else begin
      loss_q <= loss_eff;
      pass_q <= pattern_pass;
    end
  end

  // reads are taken on the edge that raises ack, writes where ack is seen
  assign bus_req   = wb_cyc & wb_stb & ~wb_ack;
  assign bus_wr    = wb_cyc & wb_stb & wb_we & wb_ack;
  assign irq_clear = (bus_wr && wb_sel[0] &&
                      wb_adr == `SDTSC_ADR_IRQ_STAT) ? wb_wdata[2:0] : 3'h0;

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clear) | irq_event;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // control register writes, low byte only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable              <= `SDTSC_ENABLE_RST;
      loopback_select     <= 1'b0;
      pattern_test_select <= 1'b0;
      irq_mask            <= `SDTSC_IRQ_MASK_RST;
    end else if (bus_wr && wb_sel[0]) begin
      if (wb_adr == `SDTSC_ADR_CTRL) begin
        enable              <= wb_wdata[`SDTSC_CTRL_ENABLE];
        loopback_select     <= wb_wdata[`SDTSC_CTRL_LOOPBACK];
        pattern_test_select <= wb_wdata[`SDTSC_CTRL_PATTERN];
      end
      if (wb_adr == `SDTSC_ADR_IRQ_MASK) begin
        irq_mask <= wb_wdata[2:0];
      end
    end
  end

  // transmit word with byte lanes; taken at the next word reload
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word        <= 16'h0000;
      tx_lower_kflag <= 1'b0;
      tx_upper_kflag <= 1'b0;
    end else if (bus_wr && wb_adr == `SDTSC_ADR_TX_WORD) begin
      if (wb_sel[0]) begin
        tx_word[7:0] <= wb_wdata[7:0];
      end
      if (wb_sel[1]) begin
        tx_word[15:8] <= wb_wdata[15:8];
      end
      if (wb_sel[2]) begin
        tx_lower_kflag <= wb_wdata[`SDTSC_FR_LOWER_K];
        tx_upper_kflag <= wb_wdata[`SDTSC_FR_UPPER_K];
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (wb_adr)
      `SDTSC_ADR_CTRL: begin
        next_rdata[`SDTSC_CTRL_ENABLE]   = enable;
        next_rdata[`SDTSC_CTRL_LOOPBACK] = loopback_select;
        next_rdata[`SDTSC_CTRL_PATTERN]  = pattern_test_select;
      end
      `SDTSC_ADR_STATUS: begin
        next_rdata[`SDTSC_ST_LOSS] = loss_eff;
        next_rdata[`SDTSC_ST_PASS] = pattern_pass;
        next_rdata[`SDTSC_ST_POR]  = (pwr_state == PWR_POR);
        next_rdata[`SDTSC_ST_DOWN] = (pwr_state == PWR_DOWN);
      end
      `SDTSC_ADR_IRQ_STAT: begin
        next_rdata[2:0] = irq_stat;
      end
      `SDTSC_ADR_IRQ_MASK: begin
        next_rdata[2:0] = irq_mask;
      end
      `SDTSC_ADR_TX_WORD: begin
        next_rdata[15:0]                = tx_word;
        next_rdata[`SDTSC_FR_LOWER_K]   = tx_lower_kflag;
        next_rdata[`SDTSC_FR_UPPER_K]   = tx_upper_kflag;
      end
      `SDTSC_ADR_RX_WORD: begin
        next_rdata[17:0] = rx_frame[17:0];
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // single-wait answer: ack one cycle after the strobe, then drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack   <= 1'b0;
      wb_rdata <= 32'h00000000;
    end else begin
      wb_ack <= bus_req;
      if (bus_req && !wb_we) begin
        wb_rdata <= next_rdata;
      end
    end
  end

endmodule : sdtsc_top

// ---- sim/sdtsc_far_end.sv ----
// far-end model: remote line sender and loss detector
`timescale 1ns/10ps
module sdtsc_far_end (
  // clock
  input  wire logic clk,
  // bench command
  input  wire logic loss_cmd,
  // toward the block
  output logic      serial_in,
  output logic      signal_loss
);
  // no valid pattern arrives: inverse of the last bit every slot
  initial begin
    serial_in   = 1'b0;
    signal_loss = 1'b0;
    forever @(posedge clk) begin
      serial_in   <= ~serial_in;
      signal_loss <= loss_cmd;
    end
  end
endmodule : sdtsc_far_end

// ---- sim/sdtsc_top_props.sv ----
// port assertions for the test and status control top
`timescale 1ns/10ps
module sdtsc_top_props
  import sdtsc_pkg::*;
#(
  parameter int POR_TIME_NS = 1000000
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // bus
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [7:0]  wb_adr,
  input wire logic [31:0] wb_rdata,
  input wire logic        wb_ack,
  // line
  input wire logic        signal_loss,
  input wire logic        serial_out,
  input wire logic        serial_oe,
  // receive pins
  input wire sdtsc_word_t rx_data,
  input wire logic        rx_data_oe,
  input wire logic        rx_upper_kflag_or_sigloss,
  input wire logic        rx_upper_oe,
  input wire logic        rx_lower_oe,
  input wire logic        rx_word_clock
);
  localparam int POR_CYC = POR_TIME_NS / 100;
  logic [15:0] por_cnt;
  logic [4:0]  hi_cnt;
  logic [4:0]  lo_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles spent with the upper pin floating, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      por_cnt <= 16'h0;
    else if (!rx_upper_oe && por_cnt != 16'hFFFF)
      por_cnt <= por_cnt + 16'h1;
  end

  // high and low run lengths of the word clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 5'h0;
      lo_cnt <= 5'h0;
    end else if (rx_word_clock) begin
      hi_cnt <= hi_cnt + 5'h1;
      lo_cnt <= 5'h0;
    end else begin
      hi_cnt <= 5'h0;
      if (lo_cnt != 5'h1F)
        lo_cnt <= lo_cnt + 5'h1;
    end
  end

  sequence s_bus_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  // five slots gives the two-flop sync time to land
  sequence s_loss_held;
    (signal_loss && serial_oe)[*5];
  endsequence

  a_ack_one_pulse: assert property (s_bus_req |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single pulse one cycle after request");
  a_unmapped_zero: assert property (
    s_bus_req and (!wb_we && wb_adr == 8'hFC) |=> wb_rdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_loss_all_ones: assert property (
    s_loss_held |-> rx_data == 16'hFFFF && rx_upper_kflag_or_sigloss)
    else $error("signal loss did not force all ones");
  a_por_floats: assert property (!rx_upper_oe |->
    !rx_data_oe && !rx_lower_oe && !rx_word_clock && !serial_oe)
    else $error("pins driven during power-on reset");
  a_por_length: assert property ($rose(rx_upper_oe) |->
    por_cnt >= POR_CYC - 1 && por_cnt <= POR_CYC + 21)
    else $error("power-on reset length off");
  a_down_floats: assert property (
    (!rx_data_oe && rx_upper_oe)[*2] |->
    !serial_oe && !serial_out && !rx_lower_oe && !rx_word_clock)
    else $error("pins active in power-down");
  a_drive_needs_run: assert property (serial_oe |-> rx_data_oe)
    else $error("serial driver on while block not running");
  a_word_high_ten: assert property (
    $fell(rx_word_clock) && rx_lower_oe |-> hi_cnt == 5'd10)
    else $error("word clock high phase not ten slots");
  a_word_low_ten: assert property (
    $rose(rx_word_clock) && lo_cnt != 5'h1F |-> lo_cnt == 5'd10)
    else $error("word clock low phase not ten slots");
endmodule : sdtsc_top_props

// ---- sim/serdes_test_and_status_control_bench.sv ----
// self-checking bench for the test and status control top
`timescale 1ns/10ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module serdes_test_and_status_control_bench;
  import sdtsc_pkg::*;
  logic        clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, loss_cmd;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, sel_nx;
  logic [31:0] wb_wdata, wb_rdata, w, me, mm;
  logic        serial_in, signal_loss, serial_out, serial_oe, irq;
  logic        rx_data_oe, rx_up, rx_up_oe, rx_lo, rx_lo_oe, rx_wclk;
  sdtsc_word_t rx_data;
  int          bad_count, total_checks, n;
  logic [31:0] exp_q[$], msk_q[$];

  sdtsc_top #(.POR_TIME_NS(20000)) uut (
    .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
    .serial_in(serial_in), .signal_loss(signal_loss),
    .serial_out(serial_out), .serial_oe(serial_oe), .rx_data(rx_data),
    .rx_data_oe(rx_data_oe), .rx_upper_kflag_or_sigloss(rx_up),
    .rx_upper_oe(rx_up_oe), .rx_lower_kflag_or_pattern_pass(rx_lo),
    .rx_lower_oe(rx_lo_oe), .rx_word_clock(rx_wclk), .irq(irq));
  sdtsc_far_end u_far (.clk(clk), .loss_cmd(loss_cmd),
    .serial_in(serial_in), .signal_loss(signal_loss));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // one classic cycle; waits for ack, then releases
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= sel_nx;
    wb_wdata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50)
      bad_count++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  // read with an expected value noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb_xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // read data is taken at the very edge that shows ack
  always @(posedge clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      `CHK(wb_rdata & mm, me)
    end
  end

  // watchdog well past the expected run of about 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    {wb_cyc, wb_stb, wb_we, loss_cmd} = 4'h0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    sel_nx = 4'hF;
    wb_wdata = 32'h0;
    w = $urandom(32'hC038);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h1, 32'hFFFFFFFF);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF);
    rd(8'h04, 32'h4, 32'hF);
    `CHK({rx_up_oe, rx_wclk}, 2'b00)
    wb_xfer(1'b1, 8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    for (n = 0; n < 400 && rx_up_oe !== 1'b1; n++)
      @(posedge clk);
    `CHK(rx_up_oe, 1'b1)
    $display("test reset done");
    // loopback of random words and control flags
    wb_xfer(1'b1, 8'h00, 32'h3);
    for (int i = 0; i < 3; i++) begin
      w = $urandom & 32'h3FFFF;
      wb_xfer(1'b1, 8'h10, w);
      repeat (60) @(posedge clk);
      rd(8'h14, w, 32'h3FFFF);
      `CHK({rx_up, rx_lo, rx_data}, w[17:0])
      `CHK(serial_oe, 1'b0)
    end
    // only the low byte lane is written
    sel_nx = 4'h1;
    wb_xfer(1'b1, 8'h10, 32'h3FFFF);
    sel_nx = 4'hF;
    rd(8'h10, {w[31:8], 8'hFF}, 32'h3FFFF);
    $display("test loopback done");
    // signal loss with its interrupt
    wb_xfer(1'b1, 8'h00, 32'h1);
    loss_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({rx_up, rx_lo, rx_data}, 18'h3FFFF)
    rd(8'h04, 32'h1, 32'h1);
    rd(8'h08, 32'h1, 32'h1);
    `CHK(irq, 1'b0)
    wb_xfer(1'b1, 8'h0C, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    loss_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    wb_xfer(1'b1, 8'h08, 32'h7);
    rd(8'h08, 32'h0, 32'h1);
    `CHK(irq, 1'b0)
    $display("test loss done");
    // self-test: pattern mode through loopback
    wb_xfer(1'b1, 8'h00, 32'h7);
    wb_xfer(1'b1, 8'h08, 32'h7);
    for (n = 0; n < 600 && rx_lo !== 1'b1; n++)
      @(posedge clk);
    `CHK(rx_lo, 1'b1)
    rd(8'h04, 32'h2, 32'h2);
    rd(8'h08, 32'h4, 32'h4);
    $display("test self-test done");
    // pattern mode against a far end sending no pattern
    wb_xfer(1'b1, 8'h00, 32'h5);
    wb_xfer(1'b1, 8'h08, 32'h7);
    repeat (300) @(posedge clk);
    `CHK(rx_lo, 1'b0)
    rd(8'h08, 32'h2, 32'h2);
    $display("test pattern error done");
    // power-down and back
    wb_xfer(1'b1, 8'h00, 32'h0);
    repeat (40) @(posedge clk);
    `CHK({rx_data_oe, serial_oe, rx_lo_oe, rx_up_oe}, 4'h1)
    rd(8'h04, 32'h8, 32'h8);
    wb_xfer(1'b1, 8'h00, 32'h1);
    repeat (60) @(posedge clk);
    `CHK({rx_data_oe, serial_oe}, 2'b11)
    $display("test power-down done");
    finish_test();
  end
endmodule : serdes_test_and_status_control_bench

bind sdtsc_top sdtsc_top_props #(.POR_TIME_NS(POR_TIME_NS)) u_props (
  .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
  .signal_loss(signal_loss), .serial_out(serial_out),
  .serial_oe(serial_oe), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
  .rx_upper_kflag_or_sigloss(rx_upper_kflag_or_sigloss),
  .rx_upper_oe(rx_upper_oe), .rx_lower_oe(rx_lower_oe),
  .rx_word_clock(rx_word_clock));
